// ===== lodic_top.sv
/*
 * register bank, two-wire slave, converter sequencer, jam and swing control.
 * assumes scl and sda as open-drain pins, alarm comparators and converter
 * handshakes from the analog side; sys_rst is the power-on reset.
 */
`timescale 1ns/100ps
module lodic_top
    import lodic_pkg::*;
(
    // clock and power-on reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // two-wire bus
    input  wire logic        scl,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // control pins
    input  wire logic        swing_select_pin,
    input  wire logic        force_pin,
    output logic             loss_n_o,
    output logic             loss_n_oe,
    // alarm comparators
    input  wire logic        loss_cmp,
    input  wire logic        temp_cmp,
    input  wire logic        supply_cmp,
    // converter
    input  wire logic [7:0]  adc_data,
    input  wire logic        adc_done,
    output logic             adc_start,
    output logic [1:0]       adc_channel,
    // output stage
    output logic [10:0]      swing_mv,
    output logic             driver_enable,
    output logic             force_zero
);

    // ********************************
    // input synchronisers
    // ********************************
    localparam int NS = 7;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic [NS-1:0] sync3;
    logic [NS-1:0] stable;
    logic          scl_q;
    logic          sda_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1  <= RST_PIN_IDLE;
            sync2  <= RST_PIN_IDLE;
            sync3  <= RST_PIN_IDLE;
            stable <= RST_PIN_IDLE;
        end else begin
            sync1 <= {scl, sda_i, swing_select_pin, force_pin,
                      loss_cmp, supply_cmp, temp_cmp};
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < NS; i++) begin
                if (sync2[i] == sync3[i]) begin
                    stable[i] <= sync3[i];
                end
            end
        end
    end

    wire logic scl_s  = stable[6];
    wire logic sda_s  = stable[5];
    wire logic lvl_s  = stable[4];
    wire logic frc_s  = stable[3];
    lodic_alarm_t present;
    assign present = lodic_alarm_t'(stable[2:0]);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    wire logic scl_rise = scl_s & ~scl_q;
    wire logic scl_fall = ~scl_s & scl_q;
    wire logic start_c  = scl_s & scl_q & sda_q & ~sda_s;
    wire logic stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    // ********************************
    // registers
    // ********************************
    lodic_cfg_t   cfg;
    lodic_alarm_t history;
    lodic_alarm_t status;
    logic [7:0]   result [NUM_CHAN];
    logic         cfg_we;
    logic [7:0]   cfg_wdata;
    logic         hist_clr;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg <= lodic_cfg_t'(RST_SWING_CFG);
        end else if (cfg_we) begin
            cfg <= lodic_cfg_t'(cfg_wdata);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            history <= '0;
            status  <= '0;
        end else begin
            history <= (hist_clr ? lodic_alarm_t'(3'h0) : history) | present;
            status  <= present;
        end
    end

    function automatic logic [7:0] read_value(input logic [7:0] ofs);
        logic [7:0] v;
        v = 8'h00;
        case (ofs)
            OFS_HISTORY:   v = {5'h00, history};
            OFS_PRESENT:   v = {5'h00, status};
            OFS_TEMP:      v = result[0];
            OFS_SUPPLY:    v = result[1];
            OFS_LEVEL:     v = result[2];
            OFS_EXTV:      v = result[3];
            OFS_SWING_CFG: v = cfg;
            default:       v = 8'h00;
        endcase
        return v;
    endfunction : read_value

    // ********************************
    // converter sequencer
    // ********************************
    logic adc_busy;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adc_start   <= 1'b0;
            adc_busy    <= 1'b0;
            adc_channel <= 2'h0;
            for (int i = 0; i < NUM_CHAN; i++) begin
                result[i] <= RST_RESULT;
            end
        end else begin
            adc_start <= 1'b0;
            if (!adc_busy) begin
                adc_start <= 1'b1;
                adc_busy  <= 1'b1;
            end else if (adc_done && !adc_start) begin
                result[adc_channel] <= adc_data;
                adc_channel         <= adc_channel + 2'h1;
                adc_busy            <= 1'b0;
            end
        end
    end

    // ********************************
    // output stage control
    // ********************************
    logic pin_jam;
    assign pin_jam = cfg.force_input_polarity ? frc_s : ~frc_s;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            force_zero <= 1'b0;
        end else begin
            force_zero <= pin_jam
                        | (cfg.register_force_enable & cfg.force_value)
                        | (cfg.force_on_signal_loss & present.loss);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            swing_mv      <= MV_OFF;
            driver_enable <= 1'b0;
        end else if (cfg.pin_select) begin
            swing_mv      <= lvl_s ? MV_PIN_HIGH : MV_PIN_LOW;
            driver_enable <= 1'b1;
        end else if (cfg.output_swing_select == LEVEL_OFF) begin
            swing_mv      <= MV_OFF;
            driver_enable <= 1'b0;
        end else begin
            swing_mv      <= MV_MIN + 11'(MV_STEP * 11'(cfg.output_swing_select - 3'h1));
            driver_enable <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loss_n_o  <= 1'b0;
            loss_n_oe <= 1'b0;
        end else begin
            loss_n_o  <= 1'b0;
            loss_n_oe <= present.loss;
        end
    end

    // ********************************
    // two-wire slave
    // ********************************
    lodic_state_t state;
    logic [7:0]   shreg;
    logic [3:0]   bit_cnt;
    logic [7:0]   ptr;
    logic         rd_mode;
    logic [7:0]   load_val;

    always_comb begin
        load_val = read_value(ptr);
    end
    assign cfg_we    = scl_fall && state == ST_WDATA && bit_cnt == 4'h8
                       && ptr == OFS_SWING_CFG;
    assign cfg_wdata = shreg;
    assign hist_clr  = scl_fall && ptr == OFS_HISTORY
                       && ((state == ST_ACK_ADDR && rd_mode)
                           || (state == ST_RACK && !sda_s));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state   <= ST_IDLE;
            shreg   <= 8'h00;
            bit_cnt <= 4'h0;
            ptr     <= 8'h00;
            rd_mode <= 1'b0;
            sda_o   <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (stop_c) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (start_c) begin
            state   <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
        end else if (scl_rise) begin
            if (state == ST_ADDR || state == ST_PTR || state == ST_WDATA) begin
                shreg   <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: begin
                    if (bit_cnt == 4'h8) begin
                        if (shreg[7:1] == DEV_ADDR) begin
                            state   <= ST_ACK_ADDR;
                            rd_mode <= shreg[0];
                            sda_oe  <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    bit_cnt <= 4'h0;
                    if (rd_mode) begin
                        state  <= ST_RDATA;
                        shreg  <= load_val;
                        sda_oe <= ~load_val[7];
                        if (ptr < OFS_TEMP || ptr > OFS_ADC_LAST) begin
                            ptr <= ptr + 8'h01;
                        end
                    end else begin
                        state  <= ST_PTR;
                        sda_oe <= 1'b0;
                    end
                end
                ST_PTR: begin
                    if (bit_cnt == 4'h8) begin
                        ptr    <= shreg;
                        state  <= ST_ACK_PTR;
                        sda_oe <= 1'b1;
                    end
                end
                ST_ACK_PTR: begin
                    state   <= ST_WDATA;
                    bit_cnt <= 4'h0;
                    sda_oe  <= 1'b0;
                end
                ST_WDATA: begin
                    if (bit_cnt == 4'h8) begin
                        state  <= ST_ACK_WDATA;
                        sda_oe <= 1'b1;
                    end
                end
                ST_ACK_WDATA: begin
                    state   <= ST_PTR;
                    bit_cnt <= 4'h0;
                    sda_oe  <= 1'b0;
                end
                ST_RDATA: begin
                    if (bit_cnt == 4'h7) begin
                        state  <= ST_RACK;
                        sda_oe <= 1'b0;
                    end else begin
                        shreg   <= {shreg[6:0], 1'b0};
                        sda_oe  <= ~shreg[6];
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                ST_RACK: begin
                    bit_cnt <= 4'h0;
                    if (sda_s) begin
                        state <= ST_IDLE;
                    end else begin
                        state  <= ST_RDATA;
                        shreg  <= load_val;
                        sda_oe <= ~load_val[7];
                        if (ptr < OFS_TEMP || ptr > OFS_ADC_LAST) begin
                            ptr <= ptr + 8'h01;
                        end
                    end
                end
                default: begin
                    state  <= ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule : lodic_top

// ===== lodic_pkg.sv
/*
 * constants, field layouts and carrier types of the limiter control and status block.
 * assumes a two-wire bus master outside, slow against the 40 MHz system clock.
 */
package lodic_pkg;

    // ********************************
    // bus address and register offsets
    // ********************************
    localparam logic [6:0] DEV_ADDR       = 7'h69;
    localparam logic [7:0] OFS_HISTORY    = 8'h00;
    localparam logic [7:0] OFS_PRESENT    = 8'h01;
    localparam logic [7:0] OFS_TEMP       = 8'h08;
    localparam logic [7:0] OFS_SUPPLY     = 8'h09;
    localparam logic [7:0] OFS_LEVEL      = 8'h0a;
    localparam logic [7:0] OFS_EXTV       = 8'h0b;
    localparam logic [7:0] OFS_ADC_LAST   = 8'h0c;
    localparam logic [7:0] OFS_SWING_CFG  = 8'h13;

    // ********************************
    // reset values and level figures
    // ********************************
    localparam logic [7:0]  RST_SWING_CFG = 8'h15;
    localparam logic [7:0]  RST_RESULT    = 8'h00;
    localparam logic [6:0]  RST_PIN_IDLE  = 7'h78;
    localparam logic [10:0] MV_MIN        = 11'h1f4;
    localparam logic [10:0] MV_STEP       = 11'h0fa;
    localparam logic [10:0] MV_PIN_HIGH   = 11'h622;
    localparam logic [10:0] MV_PIN_LOW    = 11'h1f4;
    localparam logic [10:0] MV_OFF        = 11'h000;
    localparam logic [2:0]  LEVEL_OFF     = 3'h0;
    localparam int          NUM_CHAN      = 4;

    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic       force_value;
        logic       register_force_enable;
        logic       force_input_polarity;
        logic       pin_select;
        logic       force_on_signal_loss;
        logic [2:0] output_swing_select;
    } lodic_cfg_t;

    typedef struct packed {
        logic loss;
        logic supply;
        logic temp;
    } lodic_alarm_t;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
        ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_RACK
    } lodic_state_t;

endpackage : lodic_pkg

// ===== lodic_props.sv
/* port checks of the limiter control block.
   assumes a bind into lodic_top, one clock, synchronous reset. */
`timescale 1ns/100ps
module lodic_props
    import lodic_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // pins
    input wire logic        scl,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic        swing_select_pin,
    input wire logic        force_pin,
    input wire logic        loss_cmp,
    input wire logic        loss_n_o,
    input wire logic        loss_n_oe,
    // converter and output stage
    input wire logic        adc_start,
    input wire logic [1:0]  adc_channel,
    input wire logic [10:0] swing_mv,
    input wire logic        driver_enable,
    input wire logic        force_zero
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       seen;
    logic [1:0] last_ch;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seen <= 1'b0;
        end else if (adc_start) begin
            seen    <= 1'b1;
            last_ch <= adc_channel;
        end
    end
    // *****
    // checks
    // *****
    AST_OPEN_DRAIN: assert property (sda_o == 1'b0 && loss_n_o == 1'b0)
        else $error("open drain pin driven high");
    AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl)
        else $error("data pulled while clock high");
    AST_LOSS_SET: assert property (loss_cmp [*8] |-> loss_n_oe)
        else $error("loss output not pulled");
    AST_LOSS_CLR: assert property (!loss_cmp [*8] |-> !loss_n_oe)
        else $error("loss output pulled without loss");
    AST_ADC_PULSE: assert property (adc_start |=> !adc_start)
        else $error("start longer than one cycle");
    AST_ADC_HOLD: assert property ($changed(adc_channel) |=> adc_start)
        else $error("channel moved without start");
    AST_ADC_ROUND: assert property (adc_start && seen |-> adc_channel == last_ch + 2'h1)
        else $error("channel order broken");
    AST_SWING_RANGE: assert property (driver_enable |-> swing_mv >= MV_MIN && swing_mv <= 11'h7d0)
        else $error("swing out of range");
    AST_SWING_OFF: assert property (!driver_enable |-> swing_mv == MV_OFF)
        else $error("swing while driver off");
    AST_DEF_SWING: assert property ($fell(sys_rst) ##0 swing_select_pin [*8] |-> swing_mv == MV_PIN_HIGH)
        else $error("default swing wrong");
    AST_DEF_JAM: assert property ($fell(sys_rst) ##0 force_pin [*8] |-> !force_zero)
        else $error("open jam pin jams");
    AST_RST_OUT: assert property ($fell(sys_rst) |-> !sda_oe && !force_zero && !driver_enable)
        else $error("outputs not reset");
endmodule : lodic_props

// ===== lodic_bus_master.sv
/* two-wire bus master model: start, stop, byte transfers, register access.
   assumes the bench resolves sda from all open-drain drivers with a pull-up. */
`timescale 1ns/100ps
module lodic_bus_master (
    // clock and resolved data line
    input  wire logic clk,
    input  wire logic sda_line,
    // pins driven by the master
    output logic      scl,
    output logic      sda_rel
);
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic start_cond;
        sda_rel <= 1'b1;
        w(8);
        scl <= 1'b1;
        w(8);
        sda_rel <= 1'b0;
        w(8);
        scl <= 1'b0;
        w(4);
    endtask : start_cond
    task automatic stop_cond;
        sda_rel <= 1'b0;
        w(4);
        scl <= 1'b1;
        w(8);
        sda_rel <= 1'b1;
        w(8);
    endtask : stop_cond
    task automatic bit_x(input logic b, output logic r);
        sda_rel <= b;
        w(4);
        scl <= 1'b1;
        w(8);
        r = sda_line;
        scl <= 1'b0;
        w(4);
    endtask : bit_x
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, r);
    endtask : rd_byte
    task automatic write_reg(input logic [7:0] adr, ptr, dat, output logic ok);
        logic a, b, c;
        start_cond();
        wr_byte(adr, a);
        wr_byte(ptr, b);
        wr_byte(dat, c);
        stop_cond();
        ok = a & b & c;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d);
        logic a;
        start_cond();
        wr_byte(8'hd2, a);
        wr_byte(ptr, a);
        start_cond();
        wr_byte(8'hd3, a);
        rd_byte(1'b0, d[15:8]);
        rd_byte(1'b1, d[7:0]);
        stop_cond();
    endtask : read_reg
endmodule : lodic_bus_master

// ===== lodic_tb_top.sv
/* self-checking bench of the limiter control block.
   assumes lodic_top, lodic_bus_master and lodic_props compiled first. */
`timescale 1ns/100ps
module lodic_tb_top
    import lodic_pkg::*;
;
    logic        clk, sys_rst, scl, sda_rel, sda_line, sda_o, sda_oe, ok;
    logic        swing_select_pin, force_pin, loss_n_o, loss_n_oe, adc_done, adc_start;
    logic        loss_cmp, temp_cmp, supply_cmp, driver_enable, force_zero;
    logic [1:0]  adc_channel;
    logic [7:0]  adc_data;
    logic [10:0] swing_mv;
    logic [15:0] rd_val;
    int          num_errors, samples_checked, cycles;
    assign sda_line = sda_rel & ~(sda_oe & ~sda_o);
    lodic_top u_lodic_top (.clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .swing_select_pin(swing_select_pin),
        .force_pin(force_pin), .loss_n_o(loss_n_o), .loss_n_oe(loss_n_oe),
        .loss_cmp(loss_cmp), .temp_cmp(temp_cmp), .supply_cmp(supply_cmp),
        .adc_data(adc_data), .adc_done(adc_done), .adc_start(adc_start),
        .adc_channel(adc_channel), .swing_mv(swing_mv), .driver_enable(driver_enable),
        .force_zero(force_zero));
    lodic_bus_master u_lodic_bus_master (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_rel(sda_rel));
    // *****
    // clock, converter answer, timeout
    // *****
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        adc_done <= adc_start;
        adc_data <= {6'h10, adc_channel};
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        u_lodic_bus_master.write_reg(8'hd2, ptr, d, ok);
        chk("write ack", 11'h1, {10'h0, ok});
        w(4);
    endtask : wr
    task automatic rdc(input logic [7:0] ptr, input logic [7:0] exp);
        u_lodic_bus_master.read_reg(ptr, rd_val);
        chk("register", {3'h0, exp}, {3'h0, rd_val[15:8]});
    endtask : rdc
    task automatic jam_chk(input logic exp);
        w(10);
        chk("jam", {10'h0, exp}, {10'h0, force_zero});
    endtask : jam_chk
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // *****
    // scenarios
    // *****
    task automatic t_defaults;
        chk("swing", MV_PIN_HIGH, swing_mv);
        chk("driver", 11'h1, {10'h0, driver_enable});
        chk("loss out", 11'h0, {10'h0, loss_n_oe});
        rdc(OFS_SWING_CFG, RST_SWING_CFG);
        rdc(8'h05, 8'h00);
    endtask : t_defaults
    task automatic t_levels;
        for (int n = 0; n < 8; n++) begin
            wr(OFS_SWING_CFG, 8'(n));
            chk("swing", n == 0 ? MV_OFF : MV_MIN + MV_STEP * 11'(n - 1), swing_mv);
            chk("driver", {10'h0, n != 0}, {10'h0, driver_enable});
        end
        wr(OFS_SWING_CFG, RST_SWING_CFG);
        swing_select_pin <= 1'b0;
        w(10);
        chk("pin low swing", MV_PIN_LOW, swing_mv);
        swing_select_pin <= 1'b1;
    endtask : t_levels
    task automatic t_jam;
        force_pin <= 1'b0;
        jam_chk(1'b1);
        force_pin <= 1'b1;
        jam_chk(1'b0);
        wr(OFS_SWING_CFG, 8'h35);
        jam_chk(1'b1);
        force_pin <= 1'b0;
        jam_chk(1'b0);
        force_pin <= 1'b1;
        wr(OFS_SWING_CFG, 8'hd5);
        jam_chk(1'b1);
        wr(OFS_SWING_CFG, 8'h55);
        jam_chk(1'b0);
        wr(OFS_SWING_CFG, 8'h1d);
        loss_cmp <= 1'b1;
        jam_chk(1'b1);
        chk("loss out", 11'h1, {10'h0, loss_n_oe});
        loss_cmp <= 1'b0;
        jam_chk(1'b0);
        wr(OFS_SWING_CFG, RST_SWING_CFG);
    endtask : t_jam
    task automatic t_adc;
        u_lodic_bus_master.read_reg(OFS_TEMP, rd_val);
        chk("result repeat", 11'h40, {3'h0, rd_val[7:0]});
        for (int k = 0; k < 4; k++) rdc(OFS_TEMP + 8'(k), 8'h40 + 8'(k));
    endtask : t_adc
    task automatic t_alarm;
        rdc(OFS_HISTORY, 8'h04);
        temp_cmp <= 1'b1;
        w(10);
        temp_cmp <= 1'b0;
        w(10);
        rdc(OFS_PRESENT, 8'h00);
        rdc(OFS_HISTORY, 8'h01);
        rdc(OFS_HISTORY, 8'h00);
        supply_cmp <= 1'b1;
        w(10);
        rdc(OFS_PRESENT, 8'h02);
        rdc(OFS_PRESENT, 8'h02);
        rdc(OFS_HISTORY, 8'h02);
        rdc(OFS_HISTORY, 8'h02);
        supply_cmp <= 1'b0;
        loss_cmp <= 1'b1;
        w(10);
        rdc(OFS_PRESENT, 8'h04);
        loss_cmp <= 1'b0;
        w(10);
        rdc(OFS_HISTORY, 8'h06);
        rdc(OFS_HISTORY, 8'h00);
    endtask : t_alarm
    task automatic t_addr_reset;
        u_lodic_bus_master.write_reg(8'hd4, OFS_SWING_CFG, 8'h00, ok);
        chk("wrong address ack", 11'h0, {10'h0, ok});
        chk("swing kept", MV_PIN_HIGH, swing_mv);
        wr(OFS_SWING_CFG, 8'h00);
        sys_rst <= 1'b1;
        w(16);
        sys_rst <= 1'b0;
        w(16);
        chk("swing after reset", MV_PIN_HIGH, swing_mv);
    endtask : t_addr_reset
    initial begin
        sys_rst          = 1'b1;
        swing_select_pin = 1'b1;
        force_pin        = 1'b1;
        loss_cmp         = 1'b0;
        temp_cmp         = 1'b0;
        supply_cmp       = 1'b0;
        w(16);
        sys_rst <= 1'b0;
        w(16);
        t_defaults();
        t_levels();
        t_jam();
        t_adc();
        t_alarm();
        t_addr_reset();
        close_out();
    end
endmodule : lodic_tb_top

bind lodic_top lodic_props u_lodic_props (.clk(clk), .sys_rst(sys_rst), .scl(scl),
    .sda_o(sda_o), .sda_oe(sda_oe), .swing_select_pin(swing_select_pin),
    .force_pin(force_pin), .loss_cmp(loss_cmp), .loss_n_o(loss_n_o),
    .loss_n_oe(loss_n_oe), .adc_start(adc_start), .adc_channel(adc_channel),
    .swing_mv(swing_mv), .driver_enable(driver_enable), .force_zero(force_zero));
